// ---- core/dio_pkg.sv ----
// constants, register map and carrier types for the digital io routing block
package dio_pkg;

  // timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SAMPLE_PERIOD_US = 1000;
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ROUTED_FAST_HZ = 10_000;
  localparam int unsigned ROUTED_SLOW_HZ = 500;

  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] OFF_IN_STATE = 8'h00;
  localparam logic [7:0] OFF_OUT_CMD = 8'h04;
  localparam logic [7:0] OFF_IN_SFE = 8'h08;
  localparam logic [7:0] OFF_IN_INV = 8'h0C;
  localparam logic [7:0] OFF_IN_FEN = 8'h10;
  localparam logic [7:0] OFF_IN_FVAL = 8'h14;
  localparam logic [7:0] OFF_IN_ROUTE_EN = 8'h18;
  localparam logic [7:0] OFF_IN_RAW = 8'h1C;
  localparam logic [7:0] OFF_OUT_SUB1 = 8'h20;
  localparam logic [7:0] OFF_OUT_POL = 8'h24;
  localparam logic [7:0] OFF_OUT_MAN = 8'h28;
  localparam logic [7:0] OFF_OUT_MANVAL = 8'h2C;
  localparam logic [7:0] OFF_OUT_SUB5 = 8'h30;
  localparam logic [7:0] OFF_OUT_ROUTE_EN = 8'h34;
  localparam logic [7:0] OFF_OUT_ROUTE0 = 8'h40;
  localparam logic [7:0] OFF_IN_ROUTE0 = 8'h80;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // field positions
  localparam int unsigned NUM_IN_BITS = 32;
  localparam int unsigned NUM_PHYS = 16;
  localparam int unsigned NUM_OUT = 5;
  localparam int unsigned LEVEL_BASE = 16;
  localparam int unsigned NUM_SPECIAL_IN = 3;
  localparam int unsigned BRAKE_BIT = 0;
  localparam int unsigned CODE_INV_BIT = 7;
  localparam int unsigned ROUTE_SRC_LSB = 8;
  localparam int unsigned NUM_DIV = 7;

  // input source codes (lower seven bits)
  localparam logic [6:0] ISRC_ZERO = 7'h00;
  localparam logic [6:0] ISRC_PHYS_FIRST = 7'h01;
  localparam logic [6:0] ISRC_PHYS_LAST = 7'h10;
  localparam logic [6:0] ISRC_HALL_FIRST = 7'h41;
  localparam logic [6:0] ISRC_HALL_LAST = 7'h43;
  localparam logic [6:0] ISRC_ENC_FIRST = 7'h44;
  localparam logic [6:0] ISRC_ENC_LAST = 7'h46;
  localparam logic [6:0] ISRC_USB = 7'h47;
  localparam logic [6:0] ISRC_DIP_FIRST = 7'h49;
  localparam logic [6:0] ISRC_DIP_LAST = 7'h50;

  // output source codes (high byte of a route entry)
  localparam logic [7:0] OSRC_ONE = 8'h00;
  localparam logic [7:0] OSRC_ZERO = 8'h01;
  localparam logic [7:0] OSRC_ENC_FIRST = 8'h02;
  localparam logic [7:0] OSRC_ENC_LAST = 8'h08;
  localparam logic [7:0] OSRC_POS_FIRST = 8'h09;
  localparam logic [7:0] OSRC_POS_LAST = 8'h0F;

  typedef struct packed {
    logic [7:0] dip;
    logic usb;
    logic [2:0] enc;
    logic [2:0] hall;
    logic [15:0] phys;
  } in_pins_t;

endpackage

// ---- core/pulse_divider.sv ----
// pulse train generator from a changing count, with power-of-two dividers
`timescale 1ns/1ps
module pulse_divider (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [31:0] count_value,
  output logic [dio_pkg::NUM_DIV-1:0] train
);

  typedef struct packed {
    logic [31:0] last;
    logic [dio_pkg::NUM_DIV-1:0] steps;
  } pd_state_t;

  pd_state_t st_reg;
  pd_state_t st_next;

  // one step per cycle in which the count moves; bit k is the train divided by 2**k
  always_comb begin
    st_next = st_reg;
    st_next.last = count_value;
    if (count_value != st_reg.last) begin
      st_next.steps = st_reg.steps + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign train = st_reg.steps;

endmodule

// ---- core/dio_routing.sv ----
// digital input conditioning and routing, output command and routing, axi4-lite registers
//
// Behaviour
// - bit 16 holds conditioned input 1; bit 0 is its negative-limit special function.
// - while input routing is on, enable, invert and force entries are ignored.
// - switching input routing on preloads the table to mimic previous enable and invert settings; force entries are not carried over.
// - input route entry k selects the source of input state bit k.
// - input codes select zero, physical, hall, encoder, usb power or dip sources.
// - bit 7 of an input code inverts the source; 0x80 is constant one.
// - output n follows command bit 15+n; bits 0 to 15 are special functions.
// - command bit 0 controls the brake output.
// - polarity bit set makes a command one drive the output low.
// - manual-control bit set drives the output from the manual-value bit, brake included.
// - output control entries one and five are stored but act on nothing.
// - output routing enable overrides output control entries two to four.
// - route entries map to brake, output 1, output 2, output 3, output 4.
// - route entry is 16 bits: high byte source, low byte gating bit index.
// - gating bit one passes the signal; bit 7 set makes zero pass instead.
// - output source 0x00 is constant one, 0x01 constant zero.
// - sources 0x02 to 0x08 give the encoder train divided by 1 to 64.
// - sources 0x09 to 0x0F give the position train divided by 1 to 64.
// - brake and outputs 1 and 2 reach 10 kHz, others 500 Hz; no limit is applied here, all five outputs follow the trains every clock.
// - inputs are sampled once per millisecond; shorter pulses may be missed.
// - both words carry special functions in bits 0-15, levels in 16-31.
`timescale 1ns/1ps
module dio_routing #(
  parameter int unsigned SAMPLE_CYCLES = dio_pkg::SAMPLE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire dio_pkg::in_pins_t in_pins,
  input wire logic [31:0] encoder_count_source,
  input wire logic [31:0] actual_position_source,
  output logic [dio_pkg::NUM_OUT-1:0] out_o,
  output logic [dio_pkg::NUM_OUT-1:0] out_oe,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    dio_pkg::in_pins_t sync1;
    dio_pkg::in_pins_t sync2;
    dio_pkg::in_pins_t sampled;
    logic [15:0] tick_cnt;
    logic tick;
    logic [31:0] in_state;
    logic [31:0] out_cmd;
    logic [31:0] in_sfe;
    logic [31:0] in_inv;
    logic [31:0] in_fen;
    logic [31:0] in_fval;
    logic in_route_en;
    logic [31:0][7:0] in_route;
    logic [31:0] out_sub1;
    logic [31:0] out_pol;
    logic [31:0] out_man;
    logic [31:0] out_manval;
    logic [31:0] out_sub5;
    logic out_route_en;
    logic [4:0][15:0] out_route;
    logic [4:0] out_level;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } dio_state_t;

  dio_state_t st_reg;
  dio_state_t st_next;
  logic [dio_pkg::NUM_DIV-1:0] enc_train;
  logic [dio_pkg::NUM_DIV-1:0] pos_train;

  localparam logic [15:0] TICK_LAST = 16'(SAMPLE_CYCLES - 1);

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // input source code to level; undefined codes give 0 whatever bit 7 says
  function automatic logic in_source(input logic [7:0] code, input dio_pkg::in_pins_t p);
    logic [6:0] sel;
    logic lvl;
    logic ok;
    sel = code[6:0];
    lvl = 1'b0;
    ok = 1'b1;
    if (sel == dio_pkg::ISRC_ZERO) begin
      lvl = 1'b0;
    end else if (sel >= dio_pkg::ISRC_PHYS_FIRST && sel <= dio_pkg::ISRC_PHYS_LAST) begin
      lvl = p.phys[4'(sel - dio_pkg::ISRC_PHYS_FIRST)];
    end else if (sel >= dio_pkg::ISRC_HALL_FIRST && sel <= dio_pkg::ISRC_HALL_LAST) begin
      lvl = p.hall[2'(sel - dio_pkg::ISRC_HALL_FIRST)];
    end else if (sel >= dio_pkg::ISRC_ENC_FIRST && sel <= dio_pkg::ISRC_ENC_LAST) begin
      lvl = p.enc[2'(sel - dio_pkg::ISRC_ENC_FIRST)];
    end else if (sel == dio_pkg::ISRC_USB) begin
      lvl = p.usb;
    end else if (sel >= dio_pkg::ISRC_DIP_FIRST && sel <= dio_pkg::ISRC_DIP_LAST) begin
      lvl = p.dip[3'(sel - dio_pkg::ISRC_DIP_FIRST)];
    end else begin
      ok = 1'b0;
    end
    return ok & (lvl ^ code[dio_pkg::CODE_INV_BIT]);
  endfunction

  // output route entry to the ungated signal
  function automatic logic out_source(input logic [7:0] code,
                                      input logic [dio_pkg::NUM_DIV-1:0] enc,
                                      input logic [dio_pkg::NUM_DIV-1:0] pos);
    logic sig;
    sig = 1'b0;
    if (code == dio_pkg::OSRC_ONE) begin
      sig = 1'b1;
    end else if (code == dio_pkg::OSRC_ZERO) begin
      sig = 1'b0;
    end else if (code >= dio_pkg::OSRC_ENC_FIRST && code <= dio_pkg::OSRC_ENC_LAST) begin
      sig = enc[3'(code - dio_pkg::OSRC_ENC_FIRST)];
    end else if (code >= dio_pkg::OSRC_POS_FIRST && code <= dio_pkg::OSRC_POS_LAST) begin
      sig = pos[3'(code - dio_pkg::OSRC_POS_FIRST)];
    end else begin
      sig = 1'b0;
    end
    return sig;
  endfunction

  // trains run at the clock rate, far above both routed frequency limits
  pulse_divider enc_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .count_value(encoder_count_source),
    .train(enc_train)
  );

  pulse_divider pos_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .count_value(actual_position_source),
    .train(pos_train)
  );

  always_comb begin
    logic [31:0] word;
    logic [31:0] wval;
    logic [4:0] ci;
    logic [7:0] gidx;
    logic gate;
    logic lvl;
    word = '0;
    wval = '0;
    ci = '0;
    gidx = '0;
    gate = 1'b0;
    lvl = 1'b0;
    st_next = st_reg;

    // pin synchroniser, then the millisecond sample
    st_next.sync1 = in_pins;
    st_next.sync2 = st_reg.sync1;
    st_next.tick = (st_reg.tick_cnt == TICK_LAST);
    st_next.tick_cnt = st_next.tick ? 16'h0000 : st_reg.tick_cnt + 16'h0001;
    if (st_reg.tick) begin
      st_next.sampled = st_reg.sync2;
    end

    // input state word, rebuilt from the latest sample
    if (st_reg.in_route_en) begin
      for (int k = 0; k < 32; k++) begin
        word[k] = in_source(st_reg.in_route[k], st_reg.sampled);
      end
    end else begin
      for (int i = 0; i < dio_pkg::NUM_PHYS; i++) begin
        lvl = st_reg.in_fen[dio_pkg::LEVEL_BASE + i] ? st_reg.in_fval[dio_pkg::LEVEL_BASE + i]
            : st_reg.sampled.phys[i] ^ st_reg.in_inv[dio_pkg::LEVEL_BASE + i];
        word[dio_pkg::LEVEL_BASE + i] = lvl;
      end
      for (int i = 0; i < dio_pkg::NUM_SPECIAL_IN; i++) begin
        lvl = st_reg.in_fen[i] ? st_reg.in_fval[i] : st_reg.sampled.phys[i] ^ st_reg.in_inv[i];
        word[i] = st_reg.in_sfe[i] & lvl;
      end
    end
    st_next.in_state = word;

    // outputs: brake on bit 0, output n on bit 15+n
    for (int n = 0; n < dio_pkg::NUM_OUT; n++) begin
      ci = (n == 0) ? 5'(dio_pkg::BRAKE_BIT) : 5'(dio_pkg::LEVEL_BASE + n - 1);
      if (st_reg.out_route_en) begin
        gidx = st_reg.out_route[n][7:0];
        gate = (gidx[6:5] == 2'b00) ? st_reg.out_cmd[gidx[4:0]] : 1'b0;
        gate = gate ^ gidx[dio_pkg::CODE_INV_BIT];
        st_next.out_level[n] = gate
            & out_source(st_reg.out_route[n][15:dio_pkg::ROUTE_SRC_LSB], enc_train, pos_train);
      end else if (st_reg.out_man[ci]) begin
        st_next.out_level[n] = st_reg.out_manval[ci];
      end else begin
        st_next.out_level[n] = st_reg.out_cmd[ci] ^ st_reg.out_pol[ci];
      end
    end

    // axi4-lite write: address and data taken in either order
    if (s_axi_awvalid && !st_reg.aw_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_have && !st_reg.bvalid) begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_have && st_reg.w_have) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = dio_pkg::RESP_OKAY;
      if (st_reg.aw_addr[7]) begin
        wval = merge({24'h000000, st_reg.in_route[st_reg.aw_addr[6:2]]}, st_reg.w_data,
                     st_reg.w_strb);
        st_next.in_route[st_reg.aw_addr[6:2]] = wval[7:0];
      end else begin
        unique case ({st_reg.aw_addr[7:2], 2'b00})
          dio_pkg::OFF_OUT_CMD:
            st_next.out_cmd = merge(st_reg.out_cmd, st_reg.w_data, st_reg.w_strb);
          dio_pkg::OFF_IN_SFE:
            st_next.in_sfe = merge(st_reg.in_sfe, st_reg.w_data, st_reg.w_strb);
          dio_pkg::OFF_IN_INV:
            st_next.in_inv = merge(st_reg.in_inv, st_reg.w_data, st_reg.w_strb);
          dio_pkg::OFF_IN_FEN:
            st_next.in_fen = merge(st_reg.in_fen, st_reg.w_data, st_reg.w_strb);
          dio_pkg::OFF_IN_FVAL:
            st_next.in_fval = merge(st_reg.in_fval, st_reg.w_data, st_reg.w_strb);
          dio_pkg::OFF_IN_ROUTE_EN: begin
            if (st_reg.w_strb[0]) begin
              st_next.in_route_en = st_reg.w_data[0];
              if (st_reg.w_data[0] && !st_reg.in_route_en) begin
                // preload so every input keeps its former enable and invert meaning; forces are not carried over
                for (int k = 0; k < 32; k++) begin
                  st_next.in_route[k] = 8'h00;
                end
                for (int i = 0; i < dio_pkg::NUM_SPECIAL_IN; i++) begin
                  st_next.in_route[i] = st_reg.in_sfe[i]
                      ? {st_reg.in_inv[i], 7'(dio_pkg::ISRC_PHYS_FIRST + i)} : 8'h00;
                end
                for (int i = 0; i < dio_pkg::NUM_PHYS; i++) begin
                  st_next.in_route[dio_pkg::LEVEL_BASE + i] =
                      {st_reg.in_inv[dio_pkg::LEVEL_BASE + i], 7'(dio_pkg::ISRC_PHYS_FIRST + i)};
                end
              end
            end
          end
          dio_pkg::OFF_OUT_SUB1:
            st_next.out_sub1 = merge(st_reg.out_sub1, st_reg.w_data, st_reg.w_strb);
          dio_pkg::OFF_OUT_POL:
            st_next.out_pol = merge(st_reg.out_pol, st_reg.w_data, st_reg.w_strb);
          dio_pkg::OFF_OUT_MAN:
            st_next.out_man = merge(st_reg.out_man, st_reg.w_data, st_reg.w_strb);
          dio_pkg::OFF_OUT_MANVAL:
            st_next.out_manval = merge(st_reg.out_manval, st_reg.w_data, st_reg.w_strb);
          dio_pkg::OFF_OUT_SUB5:
            st_next.out_sub5 = merge(st_reg.out_sub5, st_reg.w_data, st_reg.w_strb);
          dio_pkg::OFF_OUT_ROUTE_EN: begin
            if (st_reg.w_strb[0]) begin
              st_next.out_route_en = st_reg.w_data[0];
            end
          end
          default: begin
            if (st_reg.aw_addr >= dio_pkg::OFF_OUT_ROUTE0
                && st_reg.aw_addr < dio_pkg::OFF_OUT_ROUTE0 + 8'(4 * dio_pkg::NUM_OUT)) begin
              wval = merge({16'h0000, st_reg.out_route[3'(st_reg.aw_addr[4:2])]},
                           st_reg.w_data, st_reg.w_strb);
              st_next.out_route[3'(st_reg.aw_addr[4:2])] = wval[15:0];
            end else if (st_reg.aw_addr[7:2] != dio_pkg::OFF_IN_STATE[7:2]
                         && st_reg.aw_addr[7:2] != dio_pkg::OFF_IN_RAW[7:2]) begin
              st_next.bresp = dio_pkg::RESP_SLVERR;
            end
          end
        endcase
      end
    end

    // axi4-lite read
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = dio_pkg::RESP_OKAY;
      st_next.rdata = 32'h00000000;
      if (s_axi_araddr[7]) begin
        st_next.rdata = {24'h000000, st_reg.in_route[s_axi_araddr[6:2]]};
      end else begin
        unique case ({s_axi_araddr[7:2], 2'b00})
          dio_pkg::OFF_IN_STATE: st_next.rdata = st_reg.in_state;
          dio_pkg::OFF_OUT_CMD: st_next.rdata = st_reg.out_cmd;
          dio_pkg::OFF_IN_SFE: st_next.rdata = st_reg.in_sfe;
          dio_pkg::OFF_IN_INV: st_next.rdata = st_reg.in_inv;
          dio_pkg::OFF_IN_FEN: st_next.rdata = st_reg.in_fen;
          dio_pkg::OFF_IN_FVAL: st_next.rdata = st_reg.in_fval;
          dio_pkg::OFF_IN_ROUTE_EN: st_next.rdata = {31'h00000000, st_reg.in_route_en};
          dio_pkg::OFF_IN_RAW: st_next.rdata = {16'h0000, st_reg.sync2.phys};
          dio_pkg::OFF_OUT_SUB1: st_next.rdata = st_reg.out_sub1;
          dio_pkg::OFF_OUT_POL: st_next.rdata = st_reg.out_pol;
          dio_pkg::OFF_OUT_MAN: st_next.rdata = st_reg.out_man;
          dio_pkg::OFF_OUT_MANVAL: st_next.rdata = st_reg.out_manval;
          dio_pkg::OFF_OUT_SUB5: st_next.rdata = st_reg.out_sub5;
          dio_pkg::OFF_OUT_ROUTE_EN: st_next.rdata = {31'h00000000, st_reg.out_route_en};
          default: begin
            if (s_axi_araddr >= dio_pkg::OFF_OUT_ROUTE0
                && s_axi_araddr < dio_pkg::OFF_OUT_ROUTE0 + 8'(4 * dio_pkg::NUM_OUT)) begin
              st_next.rdata = {16'h0000, st_reg.out_route[3'(s_axi_araddr[4:2])]};
            end else begin
              st_next.rresp = dio_pkg::RESP_SLVERR;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // open drain: enable pulls the pin low for a low level
  assign out_o = '0;
  assign out_oe = ~st_reg.out_level;

  assign s_axi_awready = !st_reg.aw_have && !st_reg.bvalid;
  assign s_axi_wready = !st_reg.w_have && !st_reg.bvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;

endmodule

// ---- tb/dio_chk.sv ----
// bus protocol and output checks for the digital io routing block
`timescale 1ns/1ps
module dio_chk #(
  parameter int unsigned SAMPLE_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dio_pkg::NUM_OUT-1:0] out_o,
  input wire logic [dio_pkg::NUM_OUT-1:0] out_oe,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_open_drain: assert property (out_o == '0)
    else $error("output data line driven");
  a_reset_state: assert property (disable iff (1'b0)
    $rose(aresetn) |-> out_oe == 5'h1F && !s_axi_bvalid && !s_axi_rvalid)
    else $error("state after reset wrong");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer missing");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (out_oe == 5'h1E);
endmodule

// ---- tb/dio_far_side.sv ----
// far-side model: switches, sensors, motion counts and pulled-up output loads
`timescale 1ns/1ps
module dio_far_side (
  input wire logic aclk,
  input wire logic [dio_pkg::NUM_OUT-1:0] out_oe,
  input wire logic [15:0] phys_set,
  input wire logic step_en,
  output dio_pkg::in_pins_t in_pins,
  output logic [31:0] enc_count,
  output logic [31:0] pos_count,
  output logic [dio_pkg::NUM_OUT-1:0] pin_level
);
  // pull-up loads: a released open-drain pin reads high
  assign pin_level = ~out_oe;
  assign in_pins = '{dip: 8'hA5, usb: 1'b1, enc: 3'b010, hall: 3'b101, phys: phys_set};
  logic [31:0] steps = 32'h0;
  // encoder counts up, position counts down, both one step per enabled cycle
  assign enc_count = steps;
  assign pos_count = 32'h0 - steps;
  always @(posedge aclk) begin
    if (step_en) begin
      steps <= steps + 32'h1;
    end
  end
endmodule

// ---- tb/tb.sv ----
// self-checking testbench for the digital io routing block
`timescale 1ns/1ps
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [15:0] phys_set = 16'h0001;
  logic step_en = 1'b0;
  dio_pkg::in_pins_t in_pins;
  logic [31:0] enc_count, pos_count, s_axi_rdata;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [dio_pkg::NUM_OUT-1:0] out_o, out_oe, pin_level;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'hF;
  int bad_count = 0;
  int cmp_count = 0;
  always #10 aclk = ~aclk;
  dio_routing #(.SAMPLE_CYCLES(8)) i_dio_routing (.aclk, .aresetn, .ce, .in_pins,
    .encoder_count_source(enc_count), .actual_position_source(pos_count), .out_o, .out_oe,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dio_far_side i_dio_far_side (.aclk, .out_oe, .phys_set, .step_en, .in_pins, .enc_count,
    .pos_count, .pin_level);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    // answer left waiting one cycle so the hold checks see a stalled answer
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] er = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, exp);
    chk(32'(s_axi_rresp), 32'(er));
    @(posedge aclk);
  endtask
  task automatic oe_is(input logic [4:0] exp);
    repeat (2) @(posedge aclk);
    chk(32'(out_oe), 32'(exp));
  endtask
  task automatic t_reset;
    chk(32'(out_oe), 32'h1F);
    rdc(dio_pkg::OFF_OUT_ROUTE0, 32'h0);
    rdc(dio_pkg::OFF_OUT_CMD, 32'h0);
    rdc(8'h38, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(8'h38, 32'h1, 2'h2);
    $display("test reset done");
  endtask
  task automatic t_cmd;
    wr(dio_pkg::OFF_OUT_CMD, 32'h00050001);
    oe_is(5'h14);
    chk(32'(pin_level), 32'h0B);
    $display("test command done");
  endtask
  task automatic t_ctrl;
    wr(dio_pkg::OFF_OUT_POL, 32'h00010001);
    oe_is(5'h17);
    wr(dio_pkg::OFF_OUT_MAN, 32'h00020001);
    wr(dio_pkg::OFF_OUT_MANVAL, 32'h00020001);
    oe_is(5'h12);
    wr(dio_pkg::OFF_OUT_SUB1, 32'hFFFFFFFF);
    wr(dio_pkg::OFF_OUT_SUB5, 32'hFFFFFFFF);
    oe_is(5'h12);
    $display("test control done");
  endtask
  task automatic t_oroute;
    logic [15:0] rt [5] = '{16'h0005, 16'h0085, 16'h0105, 16'h1005, 16'h0003};
    wr(dio_pkg::OFF_OUT_ROUTE_EN, 32'h1);
    for (int i = 0; i < 5; i++) wr(dio_pkg::OFF_OUT_ROUTE0 + 8'(4 * i), {16'hFFFF, rt[i]});
    rdc(dio_pkg::OFF_OUT_ROUTE0 + 8'h4, 32'h0085);
    wr(dio_pkg::OFF_OUT_CMD, 32'h20);
    oe_is(5'h1E);
    wr(dio_pkg::OFF_OUT_CMD, 32'h8);
    oe_is(5'h0D);
    $display("test output routing done");
  endtask
  task automatic t_train;
    int r1, r2, r3;
    logic [4:0] p;
    r1 = 0;
    r2 = 0;
    r3 = 0;
    wr(dio_pkg::OFF_OUT_ROUTE0 + 8'h4, 32'h0200);
    wr(dio_pkg::OFF_OUT_ROUTE0 + 8'h8, 32'h0400);
    wr(dio_pkg::OFF_OUT_ROUTE0 + 8'hC, 32'h0B00);
    wr(dio_pkg::OFF_OUT_CMD, 32'h1);
    step_en <= 1'b1;
    repeat (4) @(posedge aclk);
    p = pin_level;
    repeat (64) begin
      @(posedge aclk);
      r1 += int'(pin_level[1] && !p[1]);
      r2 += int'(pin_level[2] && !p[2]);
      r3 += int'(pin_level[3] && !p[3]);
      p = pin_level;
    end
    step_en <= 1'b0;
    chk(32'(r1 inside {[31:33]}), 32'h1);
    chk(32'(r2 inside {[7:9]}), 32'h1);
    chk(32'(r3 inside {[7:9]}), 32'h1);
    $display("test pulse trains done");
  endtask
  task automatic t_input;
    logic [7:0] ic [16] = '{8'h80, 8'h01, 8'h41, 8'h42, 8'hC2, 8'h47, 8'h49, 8'h4A,
                            8'h44, 8'h45, 8'h20, 8'hA0, 8'h50, 8'h00, 8'h00, 8'h00};
    wr(dio_pkg::OFF_IN_SFE, 32'h1);
    repeat (24) @(posedge aclk);
    rdc(dio_pkg::OFF_IN_STATE, 32'h00010001, 32'h00010001);
    wr(dio_pkg::OFF_IN_INV, 32'h00010000);
    repeat (24) @(posedge aclk);
    rdc(dio_pkg::OFF_IN_STATE, 32'h0, 32'h00010000);
    wr(dio_pkg::OFF_IN_ROUTE_EN, 32'h1);
    rdc(dio_pkg::OFF_IN_ROUTE0 + 8'h40, 32'h81);
    rdc(dio_pkg::OFF_IN_ROUTE0, 32'h01);
    for (int k = 0; k < 16; k++) wr(dio_pkg::OFF_IN_ROUTE0 + 8'(64 + 4 * k), 32'(ic[k]));
    wr(dio_pkg::OFF_IN_ROUTE0, 32'h81);
    wr(dio_pkg::OFF_IN_FEN, 32'hFFFFFFFF);
    wr(dio_pkg::OFF_IN_FVAL, 32'h00020000);
    repeat (24) @(posedge aclk);
    rdc(dio_pkg::OFF_IN_STATE, 32'h12770000);
    wr(dio_pkg::OFF_IN_ROUTE_EN, 32'h0);
    repeat (24) @(posedge aclk);
    rdc(dio_pkg::OFF_IN_STATE, 32'h00020000);
    $display("test input routing done");
  endtask
  task automatic summarize;
    $display("counts: compared %0d, mismatched %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_cmd();
    t_ctrl();
    t_oroute();
    t_train();
    t_input();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    summarize();
  end
endmodule
bind dio_routing dio_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_dio_chk (.aclk, .aresetn, .out_o,
  .out_oe, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);
